// ===== hdl/dcrb_pkg.sv
// package for the converter configuration register bank: offsets, fields, resets, decodes
package dcrb_pkg;

  // register offsets (byte addresses on the serial control port)
  localparam logic [7:0] SYS_SETTINGS_OFS = 8'h00;
  localparam logic [7:0] INPUT_CFG_OFS = 8'h01;
  localparam logic [7:0] CH1_ATTEN_OFS = 8'h0F;
  localparam logic [7:0] CH2_ATTEN_OFS = 8'h10;
  localparam logic [7:0] LEVEL_TRIM_OFS = 8'h11;
  localparam logic [7:0] PIN_SRC_FILT_OFS = 8'h15;
  localparam logic [7:0] HARM2_CORR_OFS = 8'h16;
  localparam logic [7:0] HARM3_CORR_OFS = 8'h18;
  localparam logic [7:0] COEF_PTR_OFS = 8'h1A;
  localparam logic [7:0] COEF_VAL_OFS = 8'h1B;
  localparam logic [7:0] FILT_PROG_CTL_OFS = 8'h1E;
  localparam logic [7:0] WRITABLE_LAST_OFS = 8'h1E;
  localparam logic [7:0] LOCK_STATE_OFS = 8'h40;
  localparam logic [7:0] PIN_LEVELS_OFS = 8'h41;
  localparam logic [7:0] LOOP_RATIO_OFS = 8'h42;
  localparam logic [7:0] STREAM_META_OFS = 8'h46;
  localparam logic [7:0] STREAM_META_LAST_OFS = 8'h5D;

  // reset values
  localparam logic [7:0] SYS_SETTINGS_RST = 8'h00;
  localparam logic [7:0] INPUT_CFG_RST = 8'h8C;
  localparam logic [7:0] OTHER_RST = 8'h00;

  // field positions
  localparam int OSC_BIAS_MSB = 7;
  localparam int OSC_BIAS_LSB = 4;
  localparam int SOFT_RESET_BIT = 0;
  localparam int WORD_LEN_MSB = 7;
  localparam int WORD_LEN_LSB = 6;
  localparam int FRAMING_MSB = 5;
  localparam int FRAMING_LSB = 4;
  localparam int AUTO_SRC_MSB = 3;
  localparam int AUTO_SRC_LSB = 2;
  localparam int MAN_SRC_MSB = 1;
  localparam int MAN_SRC_LSB = 0;

  // oscillator bias encodings
  localparam logic [3:0] OSC_FULL = 4'h0;
  localparam logic [3:0] OSC_THREE_Q = 4'h8;
  localparam logic [3:0] OSC_HALF = 4'hC;
  localparam logic [3:0] OSC_QUARTER = 4'hE;
  localparam logic [3:0] OSC_OFF = 4'hF;

  // decoded oscillator bias setting
  typedef enum logic [2:0] {
    DCRB_BIAS_FULL = 3'h0,
    DCRB_BIAS_THREE_Q = 3'h1,
    DCRB_BIAS_HALF = 3'h3,
    DCRB_BIAS_QUARTER = 3'h2,
    DCRB_BIAS_OFF = 3'h6,
    DCRB_BIAS_RSVD = 3'h7
  } dcrb_bias_e;

  typedef enum logic [1:0] {
    DCRB_LEN_16 = 2'h0,
    DCRB_LEN_24 = 2'h1,
    DCRB_LEN_32 = 2'h3
  } dcrb_len_e;

  typedef enum logic [1:0] {
    DCRB_SRC_PCM = 2'h0,
    DCRB_SRC_SPDIF = 2'h1,
    DCRB_SRC_RSVD = 2'h2,
    DCRB_SRC_DSD = 2'h3
  } dcrb_src_e;

  typedef enum logic [1:0] {
    DCRB_AUTO_MANUAL = 2'h0,
    DCRB_AUTO_PCM_DSD = 2'h1,
    DCRB_AUTO_PCM_SPDIF = 2'h2,
    DCRB_AUTO_ALL = 2'h3
  } dcrb_auto_e;

  // decoded configuration handed to the converter core
  typedef struct packed {
    dcrb_bias_e osc_bias;
    logic osc_bias_rsvd;
    dcrb_len_e word_len;
    logic [1:0] framing;
    dcrb_auto_e auto_src;
    dcrb_src_e man_src;
    logic man_src_rsvd;
  } dcrb_cfg_s;

  // write request from the serial control port decoder
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } dcrb_wr_s;

  // read-only status from the converter core
  typedef struct packed {
    logic [7:0] lock_state;
    logic [1:0] pin_levels;
    logic [31:0] loop_ratio;
    logic [191:0] stream_meta;
  } dcrb_stat_s;

endpackage : dcrb_pkg

// ===== hdl/dcrb_bank.sv
// configuration and status register bank of the stereo converter
`timescale 1ns/100ps
`default_nettype none

module dcrb_bank (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire dcrb_pkg::dcrb_wr_s wr_i,
  input wire logic [7:0] rd_addr_i,
  input wire dcrb_pkg::dcrb_stat_s stat_i,
  output logic [7:0] rd_data_o,
  output logic chip_reset_o,
  output dcrb_pkg::dcrb_cfg_s cfg_o,
  output logic [7:0] ch1_atten_o,
  output logic [7:0] ch2_atten_o,
  output logic [31:0] level_trim_o,
  output logic [7:0] pin_src_filt_o,
  output logic [15:0] harm2_corr_o,
  output logic [15:0] harm3_corr_o,
  output logic [7:0] coef_ptr_o,
  output logic [23:0] coef_val_o,
  output logic [7:0] filt_prog_ctl_o
);

  // writable bytes 0x00..0x1E kept as one array; unnamed gaps behave as plain storage
  localparam int NWR = 31;
  logic [7:0] wreg_q [NWR];
  logic soft_rst_q;
  logic [7:0] rd_data_q;

  // serial port stores its data byte in the addressed slot
  wire wr_hit = wr_i.wr && (wr_i.addr <= dcrb_pkg::WRITABLE_LAST_OFS);
  wire [4:0] wr_idx = wr_i.addr[4:0];

  // soft reset request is the written bit 0 of system settings
  wire soft_req = wr_hit && (wr_i.addr == dcrb_pkg::SYS_SETTINGS_OFS)
                  && wr_i.data[dcrb_pkg::SOFT_RESET_BIT];
  wire bank_rst = !nrst_i || soft_rst_q;

  // reset value of each slot
  function automatic logic [7:0] rst_val(input int idx);
    if (idx == int'(dcrb_pkg::SYS_SETTINGS_OFS)) begin
      return dcrb_pkg::SYS_SETTINGS_RST;
    end else if (idx == int'(dcrb_pkg::INPUT_CFG_OFS)) begin
      return dcrb_pkg::INPUT_CFG_RST;
    end
    return dcrb_pkg::OTHER_RST;
  endfunction : rst_val

  // one-cycle internal reset pulse; bit 0 reads back as zero once it ends
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_req && !soft_rst_q;
    end
  end

  // register slots; the pulse cycle restores every writable register
  for (genvar g = 0; g < NWR; g++) begin : g_slot
    always_ff @(posedge sys_clk_i) begin
      if (bank_rst) begin
        wreg_q[g] <= rst_val(g);
      end else if (wr_hit && (wr_idx == 5'(g))) begin
        wreg_q[g] <= wr_i.data;
      end
    end
  end

  // the chip reset output carries only the soft reset pulse, not the pin reset
  assign chip_reset_o = soft_rst_q;

  // oscillator bias decode; undefined patterns flag reserved
  wire [3:0] osc_fld = wreg_q[0][dcrb_pkg::OSC_BIAS_MSB:dcrb_pkg::OSC_BIAS_LSB];
  dcrb_pkg::dcrb_bias_e bias_dec;
  always_comb begin
    unique case (osc_fld)
      dcrb_pkg::OSC_FULL: bias_dec = dcrb_pkg::DCRB_BIAS_FULL;
      dcrb_pkg::OSC_THREE_Q: bias_dec = dcrb_pkg::DCRB_BIAS_THREE_Q;
      dcrb_pkg::OSC_HALF: bias_dec = dcrb_pkg::DCRB_BIAS_HALF;
      dcrb_pkg::OSC_QUARTER: bias_dec = dcrb_pkg::DCRB_BIAS_QUARTER;
      dcrb_pkg::OSC_OFF: bias_dec = dcrb_pkg::DCRB_BIAS_OFF;
      default: bias_dec = dcrb_pkg::DCRB_BIAS_RSVD;
    endcase
  end

  // input configuration decode; word length codes 2 and 3 both mean 32 bits
  wire [1:0] len_fld = wreg_q[1][dcrb_pkg::WORD_LEN_MSB:dcrb_pkg::WORD_LEN_LSB];
  wire [1:0] man_fld = wreg_q[1][dcrb_pkg::MAN_SRC_MSB:dcrb_pkg::MAN_SRC_LSB];
  wire [1:0] auto_fld = wreg_q[1][dcrb_pkg::AUTO_SRC_MSB:dcrb_pkg::AUTO_SRC_LSB];
  wire dcrb_pkg::dcrb_len_e len_dec = (len_fld == 2'h0) ? dcrb_pkg::DCRB_LEN_16 :
                                      (len_fld == 2'h1) ? dcrb_pkg::DCRB_LEN_24 :
                                      dcrb_pkg::DCRB_LEN_32;

  // decoded fields are registered so outputs come from flip-flops
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cfg_o <= '{osc_bias: dcrb_pkg::DCRB_BIAS_FULL, osc_bias_rsvd: 1'b0,
                 word_len: dcrb_pkg::DCRB_LEN_32, framing: 2'h0,
                 auto_src: dcrb_pkg::DCRB_AUTO_ALL, man_src: dcrb_pkg::DCRB_SRC_PCM,
                 man_src_rsvd: 1'b0};
    end else begin
      cfg_o.osc_bias <= bias_dec;
      cfg_o.osc_bias_rsvd <= (bias_dec == dcrb_pkg::DCRB_BIAS_RSVD);
      cfg_o.word_len <= len_dec;
      cfg_o.framing <= wreg_q[1][dcrb_pkg::FRAMING_MSB:dcrb_pkg::FRAMING_LSB];
      cfg_o.auto_src <= dcrb_pkg::dcrb_auto_e'(auto_fld);
      cfg_o.man_src <= dcrb_pkg::dcrb_src_e'(man_fld);
      cfg_o.man_src_rsvd <= (man_fld == 2'h2);
    end
  end

  // raw register contents for the core; multi-byte fields are little-endian by offset
  assign ch1_atten_o = wreg_q[15];
  assign ch2_atten_o = wreg_q[16];
  assign level_trim_o = {wreg_q[20], wreg_q[19], wreg_q[18], wreg_q[17]};
  assign pin_src_filt_o = wreg_q[21];
  assign harm2_corr_o = {wreg_q[23], wreg_q[22]};
  assign harm3_corr_o = {wreg_q[25], wreg_q[24]};
  assign coef_ptr_o = wreg_q[26];
  assign coef_val_o = {wreg_q[29], wreg_q[28], wreg_q[27]};
  assign filt_prog_ctl_o = wreg_q[30];

  // read mux: writable slots, then status bytes; unmapped offsets read zero
  wire rd_wr = (rd_addr_i <= dcrb_pkg::WRITABLE_LAST_OFS);
  wire rd_meta = (rd_addr_i >= dcrb_pkg::STREAM_META_OFS)
                 && (rd_addr_i <= dcrb_pkg::STREAM_META_LAST_OFS);
  wire rd_ratio = (rd_addr_i >= dcrb_pkg::LOOP_RATIO_OFS) && (rd_addr_i < dcrb_pkg::STREAM_META_OFS);
  wire [7:0] meta_idx = rd_addr_i - dcrb_pkg::STREAM_META_OFS;
  wire [7:0] ratio_idx = rd_addr_i - dcrb_pkg::LOOP_RATIO_OFS;
  wire [7:0] rd_mux = rd_wr ? wreg_q[rd_addr_i[4:0]] :
                      (rd_addr_i == dcrb_pkg::LOCK_STATE_OFS) ? stat_i.lock_state :
                      (rd_addr_i == dcrb_pkg::PIN_LEVELS_OFS) ? {6'h00, stat_i.pin_levels} :
                      rd_ratio ? stat_i.loop_ratio[ratio_idx[1:0]*8 +: 8] :
                      rd_meta ? stat_i.stream_meta[meta_idx[4:0]*8 +: 8] : 8'h00;

  // read data registered one cycle after the address
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_mux;
    end
  end
  assign rd_data_o = rd_data_q;

endmodule : dcrb_bank
`default_nettype wire

// ===== bench/dcrb_bank_asserts.sv
// port checker for the converter register bank
`timescale 1ns/100ps
`default_nettype none
module dcrb_bank_asserts (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire dcrb_pkg::dcrb_wr_s wr_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic chip_reset_o,
  input wire dcrb_pkg::dcrb_cfg_s cfg_o,
  input wire logic [7:0] ch1_atten_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // writes outside a reset pulse, so the byte really lands
  wire w0 = wr_i.wr && wr_i.addr == 8'h00 && !wr_i.data[0] && !chip_reset_o;
  wire w1 = wr_i.wr && wr_i.addr == 8'h01 && !chip_reset_o;
  // expected {reserved flag, bias code}
  function automatic logic [3:0] bias_f(input logic [3:0] p);
    case (p)
      4'h0: bias_f = 4'h0;
      4'h8: bias_f = 4'h1;
      4'hC: bias_f = 4'h3;
      4'hE: bias_f = 4'h2;
      4'hF: bias_f = 4'h6;
      default: bias_f = 4'hF;
    endcase
  endfunction : bias_f
  soft_rst_a: assert property (
    wr_i.wr && wr_i.addr == 8'h00 && wr_i.data[0] && !chip_reset_o |=> chip_reset_o)
    else $error("soft reset write gave no pulse");
  pulse_once_a: assert property (chip_reset_o |=> !chip_reset_o)
    else $error("soft reset pulse too long");
  soft_clear_a: assert property (
    chip_reset_o |=> ch1_atten_o == 8'h00 ##1 cfg_o.word_len == 2'h3)
    else $error("soft reset left settings");
  sys_rd_a: assert property ((w0 ##1 rd_addr_i == 8'h00) |=>
    rd_data_o == $past(wr_i.data, 2)) else $error("system settings readback");
  cfg_rd_a: assert property ((w1 ##1 rd_addr_i == 8'h01) |=>
    rd_data_o == $past(wr_i.data, 2)) else $error("input config readback");
  bias_dec_a: assert property (w0 |-> ##2
    {cfg_o.osc_bias_rsvd, cfg_o.osc_bias} == bias_f($past(wr_i.data[7:4], 2)))
    else $error("bias decode wrong");
  word_len_a: assert property (w1 |-> ##2 cfg_o.word_len ==
    ($past(wr_i.data[7], 2) ? 2'h3 : {1'b0, $past(wr_i.data[6], 2)}))
    else $error("word length decode wrong");
  src_sel_a: assert property (w1 |-> ##2
    {cfg_o.auto_src, cfg_o.man_src} == $past(wr_i.data[3:0], 2)
    && cfg_o.man_src_rsvd == ($past(wr_i.data[1:0], 2) == 2'h2))
    else $error("source select decode wrong");
  rst_val_a: assert property (disable iff (1'b0) !nrst_i |=>
    cfg_o.word_len == 2'h3 && cfg_o.auto_src == 2'h3 && cfg_o.osc_bias == 3'h0
    && rd_data_o == 8'h00 && !chip_reset_o) else $error("reset values wrong");
  cover property (chip_reset_o);
  cover property (w0 ##2 cfg_o.osc_bias_rsvd);
  cover property (w1 ##1 rd_addr_i == 8'h01);
endmodule : dcrb_bank_asserts
bind dcrb_bank dcrb_bank_asserts dcrb_bank_asserts_inst (.sys_clk_i, .nrst_i, .wr_i,
  .rd_addr_i, .rd_data_o, .chip_reset_o, .cfg_o, .ch1_atten_o);
`default_nettype wire

// ===== bench/dcrb_host.sv
// host-side model issuing single register writes
`timescale 1ns/100ps
`default_nettype none
module dcrb_host (
  input wire logic sys_clk_i,
  output var dcrb_pkg::dcrb_wr_s wr_o
);
  initial wr_o = '0;
  // register offset then one data byte; reserved bits of offset 0 go out as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_o <= '{1'b1, a, (a == 8'h00) ? (d & 8'hF1) : d};
    @(posedge sys_clk_i);
    wr_o <= '{1'b0, ~a, ~d}; // released lines must not keep the old byte
  endtask : wr
endmodule : dcrb_host
`default_nettype wire

// ===== bench/dcrb_bank_test.sv
// self-checking bench for the converter register bank
`timescale 1ns/100ps
`default_nettype none
module dcrb_bank_test;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] rd_addr_i = 8'h00;
  dcrb_pkg::dcrb_stat_s stat_i = '0;
  dcrb_pkg::dcrb_wr_s wr_w;
  dcrb_pkg::dcrb_cfg_s cfg_o;
  logic [7:0] rd_data_o;
  logic chip_reset_o;
  logic [7:0] ch1_atten_o;
  logic [31:0] level_trim_o;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [3:0] bias_pat [6] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'hF, 4'h5};
  logic [2:0] bias_exp [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7};
  always #20 sys_clk_i = ~sys_clk_i;
  dcrb_host dcrb_host_inst (.sys_clk_i(sys_clk_i), .wr_o(wr_w));
  dcrb_bank dcrb_bank_inst (.sys_clk_i, .nrst_i, .wr_i(wr_w), .rd_addr_i, .stat_i,
    .rd_data_o, .chip_reset_o, .cfg_o, .ch1_atten_o, .ch2_atten_o(), .level_trim_o,
    .pin_src_filt_o(), .harm2_corr_o(), .harm3_corr_o(), .coef_ptr_o(), .coef_val_o(),
    .filt_prog_ctl_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read data shows one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_addr_i <= a;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(rd_data_o, e);
    @(posedge sys_clk_i);
  endtask : rd
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // hang guard, well above the roughly one hundred cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    // status bytes with distinct ends so byte order shows on readback
    stat_i <= '{8'hA5, 2'h2, 32'h44332211, {8'hEE, {22{8'h00}}, 8'h77}};
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h8C);
    chk(cfg_o.auto_src, 2'h3);
    for (int i = 0; i < 6; i++) begin
      dcrb_host_inst.wr(8'h00, {bias_pat[i], 4'h0});
      rd(8'h00, {bias_pat[i], 4'h0});
      chk({cfg_o.osc_bias_rsvd, cfg_o.osc_bias}, {i == 5, bias_exp[i]});
    end
    dcrb_host_inst.wr(8'h00, 8'h00);
    for (int c = 0; c < 4; c++) begin
      dcrb_host_inst.wr(8'h01, {4{c[1:0]}});
      rd(8'h01, {4{c[1:0]}});
      chk(cfg_o.word_len, c == 0 ? 2'h0 : c == 1 ? 2'h1 : 2'h3);
      chk({cfg_o.auto_src, cfg_o.man_src, cfg_o.man_src_rsvd}, {c[1:0], c[1:0], c == 2});
    end
    dcrb_host_inst.wr(8'h0F, 8'h5A);
    rd(8'h0F, 8'h5A);
    dcrb_host_inst.wr(8'h11, 8'h01);
    dcrb_host_inst.wr(8'h14, 8'h80);
    @(negedge sys_clk_i);
    chk(level_trim_o, 32'h80000001);
    rd(8'h40, 8'hA5);
    rd(8'h41, 8'h02);
    rd(8'h42, 8'h11);
    rd(8'h45, 8'h44);
    rd(8'h46, 8'h77);
    rd(8'h5D, 8'hEE);
    rd(8'h5E, 8'h00);
    dcrb_host_inst.wr(8'h00, 8'hF1);
    @(negedge sys_clk_i);
    chk(chip_reset_o, 1'b1);
    @(negedge sys_clk_i);
    chk(chip_reset_o, 1'b0);
    chk(ch1_atten_o, 8'h00);
    @(posedge sys_clk_i);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h8C);
    chk(cfg_o.osc_bias, 3'h0);
    dcrb_host_inst.wr(8'h20, 8'h77);
    rd(8'h20, 8'h00);
    close_out();
  end
endmodule : dcrb_bank_test
`default_nettype wire
